// ===== ebtp_pkg.sv
// Package for the eight-bit timer with prescaler: register map, fields, constants, carriers
package ebtp_pkg;

   // ****************************************
   // Register map (printed byte addresses)
   // ****************************************
   localparam logic [7:0] PRESCALER_VALUE_ADDR = 8'hD2;
   localparam logic [7:0] COUNT_VALUE_ADDR = 8'hD3;
   localparam logic [7:0] TIMER_CONTROL_ADDR = 8'hD4;

   // ****************************************
   // Reset values and reload values
   // ****************************************
   localparam logic [6:0] PRESCALER_RELOAD = 7'h7F;
   localparam logic [7:0] COUNT_RELOAD = 8'hFF;
   localparam logic [7:0] CONTROL_RESET = 8'h00;

   // ****************************************
   // Control and status field positions
   // ****************************************
   localparam int FLAG_BIT = 7;
   localparam int IRQ_EN_BIT = 6;
   localparam int DIR_BIT = 5;
   localparam int DATA_BIT = 4;
   localparam int RUN_BIT = 3;
   localparam int TAP_MSB = 2;

   // ****************************************
   // Timing: in gated and output modes the prescaler input is the internal clock divided by this
   // ****************************************
   localparam logic [3:0] INT_DIVIDE = 4'hC;
   localparam logic [3:0] INT_DIVIDE_LAST = INT_DIVIDE - 4'h1;

   // ****************************************
   // Carriers
   // ****************************************
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ebtp_bus_req_type;

   typedef struct packed {
      logic underflow_flag;
      logic underflow_irq_enable;
      logic pin_direction_select;
      logic pin_data;
      logic prescaler_run;
      logic [2:0] prescaler_tap_select;
   } ebtp_ctrl_type;

   typedef enum logic [2:0] {
      MODE_EVENT = 3'b001,
      MODE_GATED = 3'b010,
      MODE_OUTPUT = 3'b100
   } ebtp_mode_type;

endpackage

// ===== ebtp_timer.sv
// Eight-bit down-counter with seven-bit prescaler, register port and timer pin logic
//
// Strobed register access and the address map were left to the implementer.

module ebtp_timer
   import ebtp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire logic i_stop_mode,
   input wire logic i_timer_pin,
   output logic o_timer_pin,
   output logic o_timer_pin_oe_b,
   output logic o_irq,
   output logic o_wake
);

   // ****************************************
   // Register port decode
   // ****************************************
   ebtp_bus_req_type req;
   assign req = '{wr: i_wr, rd: i_rd, addr: i_addr, wdata: i_wdata};

   wire wr_presc = req.wr && (req.addr == PRESCALER_VALUE_ADDR);
   wire wr_count = req.wr && (req.addr == COUNT_VALUE_ADDR);
   wire wr_ctrl = req.wr && (req.addr == TIMER_CONTROL_ADDR);

   // ****************************************
   // State
   // ****************************************
   ebtp_ctrl_type ctrl_q, ctrl_d;
   logic [6:0] presc_q, presc_d;
   logic [7:0] count_q, count_d;
   logic [3:0] div_q, div_d;
   logic pin_prev_q;
   logic tap_prev_q;
   logic flag_prev_q;
   logic pin_out_q, pin_out_d;
   logic pin_oe_b_q;
   logic irq_q;
   logic wake_q;
   logic [7:0] rdata_q, rdata_d;

   // ****************************************
   // Mode decode
   // ****************************************
   function automatic ebtp_mode_type mode_of(input logic dir, input logic dat);
      if (dir) begin
         mode_of = MODE_OUTPUT;
      end else if (dat) begin
         mode_of = MODE_GATED;
      end else begin
         mode_of = MODE_EVENT;
      end
   endfunction

   ebtp_mode_type mode;
   assign mode = mode_of(ctrl_q.pin_direction_select, ctrl_q.pin_data);

   // ****************************************
   // Prescaler input strobe
   // ****************************************
   // The divide-by-12 counter also freezes in stop, so only the pin can feed it then
   wire div_tick = !i_stop_mode && (div_q == INT_DIVIDE_LAST);
   wire pin_rise = i_timer_pin && !pin_prev_q;
   logic presc_tick;

   always_comb begin
      case (mode)
         MODE_EVENT: presc_tick = pin_rise;
         MODE_GATED: presc_tick = div_tick && i_timer_pin;
         MODE_OUTPUT: presc_tick = div_tick;
         default: presc_tick = 1'b0;
      endcase
   end

   wire run = ctrl_q.prescaler_run;
   wire presc_step = run && presc_tick;

   assign div_d = (i_stop_mode) ? div_q :
                  (div_q == INT_DIVIDE_LAST) ? 4'h0 : div_q + 4'h1;

   // Prescaler counts down with reload at zero
   always_comb begin
      if (!run) begin
         presc_d = PRESCALER_RELOAD;
      end else if (wr_presc) begin
         presc_d = req.wdata[6:0];
      end else if (presc_step) begin
         presc_d = (presc_q == 7'h00) ? PRESCALER_RELOAD : presc_q - 7'h01;
      end else begin
         presc_d = presc_q;
      end
   end

   // ****************************************
   // Counter clock tap
   // ****************************************
   // The tap is the bit of the up-going count; presc is a down-counter, so its
   // inverted bit n gives a square wave of period 2^(n+1) steps and a rising
   // edge every 2^(n+1) prescaler steps at tap n+1, for taps one to seven.
   wire [7:0] tap_vec = {1'b0, ~presc_q};
   wire tap_lvl = (ctrl_q.prescaler_tap_select == 3'h0) ? presc_step :
                  tap_vec[ctrl_q.prescaler_tap_select - 3'h1];
   wire tap_rise = (ctrl_q.prescaler_tap_select == 3'h0) ? presc_step :
                   (run && tap_lvl && !tap_prev_q);
   wire count_step = run && tap_rise;
   wire count_to_zero = count_step && (count_q == 8'h01);

   always_comb begin
      if (wr_count) begin
         count_d = req.wdata;
      end else if (count_step) begin
         count_d = (count_q == 8'h00) ? COUNT_RELOAD : count_q - 8'h01;
      end else begin
         count_d = count_q;
      end
   end

   // ****************************************
   // Control and flag
   // ****************************************
   wire flag_set = (count_to_zero && !wr_count)
                   || (wr_count && req.wdata == 8'h00)
                   || (wr_ctrl && req.wdata[FLAG_BIT]);

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = ebtp_ctrl_type'(req.wdata);
      end
      // Hardware set wins over a software clear in the same cycle
      if (flag_set) begin
         ctrl_d.underflow_flag = 1'b1;
      end
   end

   // ****************************************
   // Timer pin
   // ****************************************
   wire flag_rise = ctrl_q.underflow_flag && !flag_prev_q;
   assign pin_out_d = flag_rise ? ctrl_q.pin_data : pin_out_q;

   // ****************************************
   // Read data
   // ****************************************
   always_comb begin
      case (req.addr)
         PRESCALER_VALUE_ADDR: rdata_d = {1'b0, presc_q};
         COUNT_VALUE_ADDR: rdata_d = count_q;
         TIMER_CONTROL_ADDR: rdata_d = ctrl_q;
         default: rdata_d = 8'h00;
      endcase
      if (!req.rd) begin
         rdata_d = 8'h00;
      end
   end

   // ****************************************
   // Registers
   // ****************************************
   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         ctrl_q <= ebtp_ctrl_type'(CONTROL_RESET);
         presc_q <= PRESCALER_RELOAD;
         count_q <= COUNT_RELOAD;
         div_q <= 4'h0;
      end else begin
         ctrl_q <= ctrl_d;
         presc_q <= presc_d;
         count_q <= count_d;
         div_q <= div_d;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         pin_prev_q <= 1'b0;
         tap_prev_q <= 1'b0;
         flag_prev_q <= 1'b0;
         pin_out_q <= 1'b0;
         pin_oe_b_q <= 1'b1;
      end else begin
         pin_prev_q <= i_timer_pin;
         tap_prev_q <= tap_lvl;
         flag_prev_q <= ctrl_q.underflow_flag;
         pin_out_q <= pin_out_d;
         pin_oe_b_q <= !ctrl_d.pin_direction_select;
      end
   end

   always_ff @(posedge i_clk_sys) begin
      if (!i_rst_b) begin
         irq_q <= 1'b0;
         wake_q <= 1'b0;
         rdata_q <= 8'h00;
      end else begin
         irq_q <= ctrl_d.underflow_flag && ctrl_d.underflow_irq_enable;
         wake_q <= ctrl_d.underflow_flag && ctrl_d.underflow_irq_enable;
         rdata_q <= rdata_d;
      end
   end

   assign o_rdata = rdata_q;
   assign o_timer_pin = pin_out_q;
   assign o_timer_pin_oe_b = pin_oe_b_q;
   assign o_irq = irq_q;
   assign o_wake = wake_q;

endmodule

// ===== ebtp_timer_asserts.sv
// Checker on the timer register port, interrupt and pin enable outputs
module ebtp_timer_asserts
   import ebtp_pkg::*;
(
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic [7:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [7:0] o_rdata,
   input wire logic o_timer_pin_oe_b,
   input wire logic o_irq,
   input wire logic o_wake
);
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);
   wire logic ctl_wr = i_wr && i_addr == TIMER_CONTROL_ADDR;
   wire logic ctl_rd = i_rd && i_addr == TIMER_CONTROL_ADDR;
   wire logic cnt_wr = i_wr && i_addr == COUNT_VALUE_ADDR;
   wire logic cnt_rd = i_rd && i_addr == COUNT_VALUE_ADDR;
   a_wake_mirrors_irq: assert property (o_wake == o_irq)
      else $error("wake differs from irq");
   a_prescaler_value_register_top_zero: assert property (
      $past(i_rd) && $past(i_addr) == PRESCALER_VALUE_ADDR |-> !o_rdata[7])
      else $error("prescaler read bit 7 set");
   // Irq seen at the read edge was built from the same control state that the read returns
   a_irq_tracks_status: assert property (ctl_rd |=> $past(o_irq) == (o_rdata[7] && o_rdata[6]))
      else $error("irq differs from flag and enable");
   a_oe_follows_dir: assert property (
      ctl_wr |=> o_timer_pin_oe_b == !$past(i_wdata[DIR_BIT]))
      else $error("pin enable does not follow direction");
   a_zero_write_flags: assert property (
      cnt_wr && i_wdata == 8'h00 ##1 ctl_rd |=> o_rdata[FLAG_BIT])
      else $error("zero count write left flag clear");
   a_bit7_write_flags: assert property (
      ctl_wr && i_wdata[FLAG_BIT] ##1 ctl_rd |=> o_rdata[FLAG_BIT])
      else $error("bit 7 write left flag clear");
   a_count_write_wins: assert property (
      cnt_wr ##1 cnt_rd |=> o_rdata == $past(i_wdata, 2))
      else $error("count read differs from write");
   a_reset_quiet: assert property (
      $rose(i_rst_b) |-> o_rdata == 8'h00 && !o_irq && o_timer_pin_oe_b)
      else $error("outputs not idle after reset");
   c_irq_up: cover property ($rose(o_irq));
   c_pin_driven: cover property (!o_timer_pin_oe_b);
   c_zero_write: cover property (cnt_wr && i_wdata == 8'h00);
endmodule
bind ebtp_timer ebtp_timer_asserts u_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b),
   .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
   .o_timer_pin_oe_b(o_timer_pin_oe_b), .o_irq(o_irq), .o_wake(o_wake));

// ===== ebtp_pin_source.sv
// Behavioural signal source and load on the timer pin, with the board pull-up
module ebtp_pin_source (
   input wire logic i_drive,
   input wire logic i_level,
   input wire logic i_dut_pin,
   input wire logic i_dut_oe_b,
   output logic o_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   // Released line rises to the pull-up, never keeps the last driven level
   assign o_pin = !i_dut_oe_b ? i_dut_pin : (i_drive ? i_level : 1'b1);
endmodule

// ===== test_eight_bit_timer_prescaler.sv
// Self-checking bench for the eight-bit timer with prescaler
module test_eight_bit_timer_prescaler
   import ebtp_pkg::*;
();
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk_sys, i_rst_b, i_stop_mode, drv, lvl, pin;
   logic o_timer_pin, o_timer_pin_oe_b, o_irq, o_wake;
   logic [7:0] o_rdata, q;
   ebtp_bus_req_type req;
   int num_errors, total_checks, pm, cm, fm, t, n;
   ebtp_timer dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_addr(req.addr),
      .i_wdata(req.wdata), .i_wr(req.wr), .i_rd(req.rd), .o_rdata(o_rdata),
      .i_stop_mode(i_stop_mode), .i_timer_pin(pin), .o_timer_pin(o_timer_pin),
      .o_timer_pin_oe_b(o_timer_pin_oe_b), .o_irq(o_irq), .o_wake(o_wake));
   ebtp_pin_source src (.i_drive(drv), .i_level(lvl), .i_dut_pin(o_timer_pin),
      .i_dut_oe_b(o_timer_pin_oe_b), .o_pin(pin));
   task automatic complete_run;
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      total_checks++;
      if (s !== e) begin
         num_errors++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Called just after an edge; strobes last one cycle, calls may follow back to back
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
      req <= '{w, !w, a, d};
      @(posedge i_clk_sys);
      req <= '0;
      #1 q = o_rdata;
   endtask
   task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(nm, e, q);
   endtask
   // Pin pulses with the reference prescaler and counter stepped alongside
   task automatic pulse(input int k);
      repeat (k) begin
         lvl <= 1'b1;
         repeat (2) @(posedge i_clk_sys);
         lvl <= 1'b0;
         repeat (2) @(posedge i_clk_sys);
         #1 n = pm;
         pm = (pm == 0) ? 127 : pm - 1;
         if (t == 0 || n[t-1] && !pm[t-1]) begin
            cm = (cm + 255) % 256;
            if (cm == 0) fm = 1;
         end
      end
   endtask
   task automatic wait_irq;
      n = 0;
      while (o_irq !== 1'b1 && n < 200) begin
         @(posedge i_clk_sys);
         #1 n++;
      end
      if (n == 200) begin
         num_errors++;
         complete_run();
      end
   endtask
   initial begin
      i_clk_sys = 1'b0;
      forever #20 i_clk_sys = ~i_clk_sys;
   end
   initial begin
      num_errors = 0;
      total_checks = 0;
      i_rst_b = 1'b0;
      req = '0;
      i_stop_mode = 1'b0;
      drv = 1'b1;
      lvl = 1'b0;
      t = 0;
      void'($urandom(32'h9A09D11C));
      repeat (6) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      @(posedge i_clk_sys);
      #1 rdc("prescaler", PRESCALER_VALUE_ADDR, 8'h7F);
      rdc("count", COUNT_VALUE_ADDR, COUNT_RELOAD);
      rdc("control", TIMER_CONTROL_ADDR, CONTROL_RESET);
      rdc("unmapped", 8'hD5, 8'h00);
      bus(1'b1, COUNT_VALUE_ADDR, 8'h55);
      rdc("count", COUNT_VALUE_ADDR, 8'h55);
      pulse(3);
      bus(1'b1, PRESCALER_VALUE_ADDR, 8'h10);
      rdc("held prescaler", PRESCALER_VALUE_ADDR, 8'h7F);
      rdc("held count", COUNT_VALUE_ADDR, 8'h55);
      for (t = 0; t < 8; t++) begin
         i_stop_mode <= t[0];
         bus(1'b1, TIMER_CONTROL_ADDR, 8'h00);
         bus(1'b1, TIMER_CONTROL_ADDR, 8'h08 | t[7:0]);
         pm = 127;
         fm = 0;
         cm = $urandom_range(255, 1);
         bus(1'b1, COUNT_VALUE_ADDR, cm[7:0]);
         pulse($urandom_range(3 << t, 1));
         repeat (4) @(posedge i_clk_sys);
         #1 rdc("prescaler", PRESCALER_VALUE_ADDR, pm[7:0]);
         rdc("count", COUNT_VALUE_ADDR, cm[7:0]);
         rdc("control", TIMER_CONTROL_ADDR, {fm[0], 4'h1, t[2:0]});
         n = $urandom_range(127);
         bus(1'b1, PRESCALER_VALUE_ADDR, n[7:0]);
         rdc("loaded prescaler", PRESCALER_VALUE_ADDR, n[7:0]);
      end
      i_stop_mode <= 1'b0;
      bus(1'b1, TIMER_CONTROL_ADDR, 8'h48);
      bus(1'b1, COUNT_VALUE_ADDR, 8'h00);
      rdc("zero write flag", TIMER_CONTROL_ADDR, 8'hC8);
      chk("irq", 8'h01, {7'h00, o_irq});
      bus(1'b1, TIMER_CONTROL_ADDR, 8'h48);
      rdc("cleared flag", TIMER_CONTROL_ADDR, 8'h48);
      chk("irq", 8'h00, {7'h00, o_irq});
      bus(1'b1, TIMER_CONTROL_ADDR, 8'hC8);
      rdc("bit 7 flag", TIMER_CONTROL_ADDR, 8'hC8);
      bus(1'b1, TIMER_CONTROL_ADDR, 8'h18);
      bus(1'b1, PRESCALER_VALUE_ADDR, 8'h40);
      repeat (40) @(posedge i_clk_sys);
      #1 rdc("gated low", PRESCALER_VALUE_ADDR, 8'h40);
      drv <= 1'b0;
      repeat (60) @(posedge i_clk_sys);
      #1 bus(1'b0, PRESCALER_VALUE_ADDR, 8'h00);
      chk("gated high", 8'h01, {7'h00, q < 8'h40});
      drv <= 1'b1;
      bus(1'b1, TIMER_CONTROL_ADDR, 8'h78);
      bus(1'b1, COUNT_VALUE_ADDR, 8'h02);
      chk("pin enable", 8'h00, {7'h00, o_timer_pin_oe_b});
      wait_irq();
      // Pin latches one cycle after the flag, one edge after irq rises
      @(posedge i_clk_sys);
      #1 chk("pin high", 8'h01, {7'h00, pin});
      bus(1'b1, TIMER_CONTROL_ADDR, 8'h68);
      bus(1'b1, COUNT_VALUE_ADDR, 8'h01);
      wait_irq();
      @(posedge i_clk_sys);
      #1 chk("pin low", 8'h00, {7'h00, pin});
      complete_run();
   end
endmodule
